// ### hw/crs_defines.vh
// Purpose: constants of the core register set
// Assumes: 8-bit data, 16-bit program counter
// Notes: field positions of the flags register and operation codes
`ifndef CRS_DEFINES_VH
`define CRS_DEFINES_VH

`define CRS_FLAGS_ADDR 8'hf7
`define CRS_BIT_GIE 0
`define CRS_BIT_ZERO 1
`define CRS_BIT_CARRY 2
`define CRS_BIT_SUPER 3
`define CRS_BIT_BANK 4
`define CRS_FLAGS_RESET 8'h02
`define CRS_FLAGS_USER_MASK 8'h17
`define CRS_PC_RESET 16'h0000
`define CRS_REG_RESET 8'h00
`define CRS_PROG_LAST 16'h1fff

// destination of a result
`define CRS_DST_NONE 3'h0
`define CRS_DST_ACC 3'h1
`define CRS_DST_IDX 3'h2
`define CRS_DST_SP 3'h3
`define CRS_DST_FLAGS 3'h4

// alu operations
`define CRS_OP_MOV 4'h0
`define CRS_OP_ADD 4'h1
`define CRS_OP_ADC 4'h2
`define CRS_OP_SUB 4'h3
`define CRS_OP_AND 4'h4
`define CRS_OP_OR 4'h5
`define CRS_OP_XOR 4'h6
`define CRS_OP_ASL 4'h7
`define CRS_OP_ASR 4'h8
`define CRS_OP_RLC 4'h9
`define CRS_OP_RRC 4'ha
`define CRS_OP_CPL 4'hb
`define CRS_OP_INC 4'hc
`define CRS_OP_DEC 4'hd

// stack pointer actions
`define CRS_SP_HOLD 3'h0
`define CRS_SP_PUSH1 3'h1
`define CRS_SP_PUSH2 3'h2
`define CRS_SP_POP1 3'h3
`define CRS_SP_POP2 3'h4
`define CRS_SP_POP3 3'h5

// program counter actions
`define CRS_PC_NEXT 2'h0
`define CRS_PC_LOAD 2'h1
`define CRS_PC_HOLD 2'h2

`endif

// ### hw/crs_alu.v
// Purpose: combinational alu with zero and carry results
// Assumes: operation codes from crs_defines.vh
// Notes: rotates take carry in for rotate-through-carry; shifts shift in zero or sign
`include "crs_defines.vh"

module crs_alu (
  // operands
  input wire [3:0] op,
  input wire [7:0] src_a,
  input wire [7:0] src_b,
  input wire carry_in,
  // results
  output reg [7:0] result,
  output reg carry_out,
  output wire zero_out
);

  reg [8:0] wide;

  always @* begin
    wide = 9'h000;
    case (op)
      `CRS_OP_MOV: wide = {1'b0, src_b};
      `CRS_OP_ADD: wide = {1'b0, src_a} + {1'b0, src_b};
      `CRS_OP_ADC: wide = {1'b0, src_a} + {1'b0, src_b} + {8'h00, carry_in};
      `CRS_OP_SUB: wide = {1'b0, src_a} - {1'b0, src_b};
      `CRS_OP_AND: wide = {1'b0, src_a & src_b};
      `CRS_OP_OR: wide = {1'b0, src_a | src_b};
      `CRS_OP_XOR: wide = {1'b0, src_a ^ src_b};
      `CRS_OP_ASL: wide = {src_a, 1'b0};
      `CRS_OP_ASR: wide = {src_a[0], src_a[7], src_a[7:1]};
      `CRS_OP_RLC: wide = {src_a, carry_in};
      `CRS_OP_RRC: wide = {src_a[0], carry_in, src_a[7:1]};
      `CRS_OP_CPL: wide = {1'b0, ~src_a};
      `CRS_OP_INC: wide = {1'b0, src_a} + 9'h001;
      `CRS_OP_DEC: wide = {1'b0, src_a} - 9'h001;
      default: wide = {1'b0, src_a};
    endcase
    result = wide[7:0];
    carry_out = wide[8];
  end

  assign zero_out = (wide[7:0] == 8'h00);

endmodule // crs_alu

// ### hw/crs_core_regs.v
// Functional notes
// - 16-bit program counter spans 8 Kbyte program space; code counts on past 0x1fff to 0x2000
// - accumulator takes source addressing mode results
// - index register supplies indexed mode offset
// - stack pointer holds data-memory top of stack
// - push pop calls returns swap add move pointer
// - zero bit1, carry bit2, supervisory bit3
// - flags bit0 is global interrupt enable
// - supervisory bit not user writable, shows mode
// - carry follows each logic/arithmetic operation
// - zero follows each logic/arithmetic result
// - two 256-register banks chosen by flags bit4
// - flags readable in register space only at 0xf7
// - flag update depends on executed instruction
// - core registers change only by execution; flags bit3 follows exec_super_mode every cycle
//
// Purpose: core register set of an 8-bit microcontroller cpu
// Assumes: execution unit issues one execute strobe per instruction
// Notes: register-space reads return flags only at the flags address
`include "crs_defines.vh"

module crs_core_regs (
  // clock and reset
  input wire clk_sys,
  input wire rst_n,
  // instruction execution
  input wire exec_valid,
  input wire [3:0] exec_op,
  input wire [2:0] exec_dst,
  input wire exec_src_idx,
  input wire [7:0] exec_operand,
  input wire exec_upd_flags,
  input wire exec_swap_sp,
  input wire [2:0] exec_sp_act,
  input wire [1:0] exec_pc_act,
  input wire [15:0] exec_pc_target,
  input wire [1:0] exec_pc_len,
  input wire exec_super_mode,
  input wire exec_flags_restore,
  input wire [7:0] exec_flags_value,
  // indexed addressing
  input wire [7:0] addr_offset,
  // register space access
  input wire [7:0] rs_addr,
  input wire rs_rd,
  // register state
  output reg [15:0] program_counter_reg,
  output reg [7:0] result_accumulator,
  output reg [7:0] index_offset,
  output reg [7:0] stack_top_pointer,
  output reg [7:0] cpu_flag_state,
  output wire [7:0] indexed_addr,
  output wire [7:0] stack_push_addr,
  // flag views
  output wire global_irq_enable,
  output wire register_bank_select,
  output wire supervisor_active,
  // register space answer
  output reg rs_flags_hit,
  output reg [7:0] rs_rdata
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  reg rst_meta;
  reg rst_sync;
  wire rst_int_n;

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  assign rst_int_n = rst_sync;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function [7:0] sp_step;
    input [7:0] sp;
    input [2:0] act;
    begin
      case (act)
        `CRS_SP_PUSH1: sp_step = sp + 8'h01;
        `CRS_SP_PUSH2: sp_step = sp + 8'h02;
        `CRS_SP_POP1: sp_step = sp - 8'h01;
        `CRS_SP_POP2: sp_step = sp - 8'h02;
        `CRS_SP_POP3: sp_step = sp - 8'h03;
        default: sp_step = sp;
      endcase
    end
  endfunction

  function [7:0] user_flags;
    input [7:0] cur;
    input [7:0] val;
    begin
      // keeps supervisory and reserved bits
      user_flags = (val & `CRS_FLAGS_USER_MASK) | (cur & ~`CRS_FLAGS_USER_MASK);
    end
  endfunction

  // ----------------------------------------------------------------
  // alu
  // ----------------------------------------------------------------
  reg [7:0] alu_a;
  wire [7:0] alu_res;
  wire alu_carry;
  wire alu_zero;

  always @* begin
    case (exec_dst)
      `CRS_DST_IDX: alu_a = index_offset;
      `CRS_DST_SP: alu_a = stack_top_pointer;
      `CRS_DST_FLAGS: alu_a = cpu_flag_state;
      default: alu_a = exec_src_idx ? index_offset : result_accumulator;
    endcase
  end

  crs_alu u_alu (
    .op(exec_op),
    .src_a(alu_a),
    .src_b(exec_operand),
    .carry_in(cpu_flag_state[`CRS_BIT_CARRY]),
    .result(alu_res),
    .carry_out(alu_carry),
    .zero_out(alu_zero)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  reg [15:0] next_pc;
  reg [7:0] next_acc;
  reg [7:0] next_idx;
  reg [7:0] next_sp;
  reg [7:0] next_flags;

  always @* begin
    next_pc = program_counter_reg;
    next_acc = result_accumulator;
    next_idx = index_offset;
    next_sp = stack_top_pointer;
    next_flags = cpu_flag_state;
    if (exec_valid) begin
      case (exec_pc_act)
        `CRS_PC_NEXT: next_pc = program_counter_reg + {14'h0000, exec_pc_len};
        `CRS_PC_LOAD: next_pc = exec_pc_target;
        default: next_pc = program_counter_reg;
      endcase
      next_sp = sp_step(stack_top_pointer, exec_sp_act);
      if (exec_upd_flags) begin
        next_flags[`CRS_BIT_CARRY] = alu_carry;
        next_flags[`CRS_BIT_ZERO] = alu_zero;
      end
      case (exec_dst)
        `CRS_DST_ACC: next_acc = alu_res;
        `CRS_DST_IDX: next_idx = alu_res;
        `CRS_DST_SP: next_sp = alu_res;
        `CRS_DST_FLAGS: next_flags = user_flags(cpu_flag_state, alu_res);
        default: next_acc = result_accumulator;
      endcase
      if (exec_swap_sp) begin
        next_sp = result_accumulator;
        next_acc = stack_top_pointer;
      end
      if (exec_flags_restore) begin
        next_flags = user_flags(cpu_flag_state, exec_flags_value);
      end
    end
    next_flags[`CRS_BIT_SUPER] = exec_super_mode;
  end

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  always @(posedge clk_sys or negedge rst_int_n) begin
    if (!rst_int_n) begin
      program_counter_reg <= `CRS_PC_RESET;
      result_accumulator <= `CRS_REG_RESET;
      index_offset <= `CRS_REG_RESET;
      stack_top_pointer <= `CRS_REG_RESET;
      cpu_flag_state <= `CRS_FLAGS_RESET;
    end else begin
      program_counter_reg <= next_pc;
      result_accumulator <= next_acc;
      index_offset <= next_idx;
      stack_top_pointer <= next_sp;
      cpu_flag_state <= next_flags;
    end
  end

  // ----------------------------------------------------------------
  // address and flag views
  // ----------------------------------------------------------------
  assign indexed_addr = index_offset + addr_offset;
  assign stack_push_addr = stack_top_pointer;
  assign global_irq_enable = cpu_flag_state[`CRS_BIT_GIE];
  assign register_bank_select = cpu_flag_state[`CRS_BIT_BANK];
  assign supervisor_active = cpu_flag_state[`CRS_BIT_SUPER];

  // ----------------------------------------------------------------
  // register space read
  // ----------------------------------------------------------------
  always @(posedge clk_sys or negedge rst_int_n) begin
    if (!rst_int_n) begin
      rs_flags_hit <= 1'b0;
      rs_rdata <= `CRS_REG_RESET;
    end else begin
      rs_flags_hit <= rs_rd && (rs_addr == `CRS_FLAGS_ADDR);
      if (rs_rd && (rs_addr == `CRS_FLAGS_ADDR)) begin
        rs_rdata <= cpu_flag_state;
      end else begin
        rs_rdata <= `CRS_REG_RESET;
      end
    end
  end

endmodule // crs_core_regs

// ### sim/crs_mem_model.sv
// Purpose: data memory seen by the execution unit
// Assumes: combinational read, fixed contents
// Notes: each byte holds the inverse of its address
module crs_mem_model (
  // access
  input wire logic [7:0] addr,
  output logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  assign rdata = ~addr;
endmodule // crs_mem_model

// ### sim/crs_regs_sva.sv
// Purpose: port checker of the core register set
// Assumes: bound to crs_core_regs
// Notes: one clock domain
module crs_regs_sva (
  // inputs
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic exec_valid,
  input wire logic [2:0] exec_dst,
  input wire logic exec_swap_sp,
  input wire logic [2:0] exec_sp_act,
  input wire logic exec_super_mode,
  input wire logic [7:0] addr_offset,
  input wire logic [7:0] rs_addr,
  input wire logic rs_rd,
  // outputs
  input wire logic [7:0] result_accumulator,
  input wire logic [7:0] index_offset,
  input wire logic [7:0] stack_top_pointer,
  input wire logic [7:0] cpu_flag_state,
  input wire logic [7:0] indexed_addr,
  input wire logic global_irq_enable,
  input wire logic register_bank_select,
  input wire logic supervisor_active,
  input wire logic rs_flags_hit,
  input wire logic [7:0] rs_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  chk_flags_read: assert property (rs_rd && rs_addr == 8'hf7 |=> rs_flags_hit && rs_rdata == $past(cpu_flag_state))
    else $error("flags read mismatch");
  chk_other_addr: assert property (rs_rd && rs_addr != 8'hf7 |=> !rs_flags_hit && rs_rdata == 8'h00)
    else $error("read outside flags address");
  chk_super_copy: assert property (1'b1 |=> cpu_flag_state[3] == $past(exec_super_mode))
    else $error("supervisor bit wrong");
  chk_flag_views: assert property (global_irq_enable == cpu_flag_state[0] && register_bank_select == cpu_flag_state[4]
    && supervisor_active == cpu_flag_state[3])
    else $error("flag view wrong");
  chk_rsv_zero: assert property (cpu_flag_state[7:5] == 3'h0)
    else $error("reserved flags set");
  chk_idle_hold: assert property (!exec_valid |=> $stable(result_accumulator) && $stable(index_offset)
    && $stable(stack_top_pointer))
    else $error("register moved without execution");
  chk_sp_push: assert property (exec_valid && exec_sp_act == 3'h1 && exec_dst != 3'h3 && !exec_swap_sp
    |=> stack_top_pointer == $past(stack_top_pointer) + 8'h01)
    else $error("push did not advance pointer");
  chk_index_sum: assert property (indexed_addr == index_offset + addr_offset)
    else $error("indexed address wrong");
  cov_flags_read: cover property (rs_rd && rs_addr == 8'hf7);
  cov_push: cover property (exec_valid && exec_sp_act == 3'h1);
  cov_super: cover property (supervisor_active);
endmodule // crs_regs_sva
bind crs_core_regs crs_regs_sva chk_i (.*);

// ### sim/testbench.sv
// Purpose: self-checking bench of the core register set
// Assumes: inputs change on the falling edge
// Notes: memory model feeds indexed loads
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 0, rst_n = 0, exec_valid = 0, exec_src_idx = 0, exec_upd_flags = 0;
  logic exec_swap_sp = 0, exec_super_mode = 0, exec_flags_restore = 0, rs_rd = 0;
  logic [3:0] exec_op = '0;
  logic [2:0] exec_dst = '0, exec_sp_act = '0;
  logic [1:0] exec_pc_act = 2'h2, exec_pc_len = 2'h0;
  logic [15:0] exec_pc_target = '0, program_counter_reg;
  logic [7:0] exec_operand = '0, exec_flags_value = '0, addr_offset = 8'h03, rs_addr = '0, mem_rdata;
  logic [7:0] result_accumulator, index_offset, stack_top_pointer, cpu_flag_state, indexed_addr, stack_push_addr;
  logic [7:0] rs_rdata;
  logic global_irq_enable, register_bank_select, supervisor_active, rs_flags_hit;
  logic [7:0] sp_exp[5] = '{8'h01, 8'h03, 8'h02, 8'h00, 8'hfd};
  int err_total = 0, cmp_count = 0, cyc = 0;
  crs_core_regs dut (.*);
  crs_mem_model mem (.addr(indexed_addr), .rdata(mem_rdata));
  initial forever #12.5 clk_sys = ~clk_sys;
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic ex(input logic [3:0] o, input logic [2:0] d, input logic [7:0] v, input logic [2:0] s);
    @(negedge clk_sys);
    exec_op = o;
    exec_dst = d;
    exec_operand = v;
    exec_sp_act = s;
    exec_upd_flags = (d != 3'h4);
    exec_valid = 1'b1;
    @(negedge clk_sys);
    exec_valid = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic h);
    @(negedge clk_sys);
    rs_addr = a;
    rs_rd = 1'b1;
    @(negedge clk_sys);
    rs_rd = 1'b0;
    chk({rs_flags_hit, rs_rdata}, {7'h00, h, e});
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 2000) begin
      err_total++;
      final_report();
    end
  end
  initial begin
    repeat (10) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk({result_accumulator, index_offset}, 16'h0000);
    chk({stack_top_pointer, cpu_flag_state}, 16'h0002);
    rd(8'hf7, 8'h02, 1'b1);
    rd(8'hf6, 8'h00, 1'b0);
    ex(4'h0, 3'h1, 8'h80, 3'h0);
    chk({result_accumulator, 7'h00, cpu_flag_state[1]}, 16'h8000);
    ex(4'h1, 3'h1, 8'h80, 3'h0);
    chk({result_accumulator, 6'h00, cpu_flag_state[2:1]}, 16'h0003);
    ex(4'h1, 3'h1, 8'h01, 3'h0);
    chk({result_accumulator, 6'h00, cpu_flag_state[2:1]}, 16'h0100);
    ex(4'h0, 3'h2, 8'h05, 3'h0);
    chk(indexed_addr, 16'h0008);
    ex(4'h0, 3'h1, mem_rdata, 3'h0);
    chk(result_accumulator, 16'h00f7);
    foreach (sp_exp[i]) begin
      ex(4'h0, 3'h0, 8'h00, 3'(i + 1));
      chk(stack_top_pointer, sp_exp[i]);
    end
    exec_swap_sp = 1'b1;
    ex(4'h0, 3'h0, 8'h00, 3'h0);
    exec_swap_sp = 1'b0;
    chk({result_accumulator, stack_top_pointer}, 16'hfdf7);
    ex(4'h5, 3'h4, 8'hff, 3'h0);
    chk({5'h00, global_irq_enable, register_bank_select, supervisor_active, cpu_flag_state}, 16'h0617);
    rd(8'hf7, 8'h17, 1'b1);
    ex(4'h4, 3'h4, 8'h00, 3'h0);
    chk({global_irq_enable, register_bank_select, cpu_flag_state}, 16'h0000);
    exec_super_mode = 1'b1;
    @(negedge clk_sys);
    chk({supervisor_active, cpu_flag_state}, 16'h0108);
    exec_super_mode = 1'b0;
    exec_pc_act = 2'h1;
    exec_pc_target = 16'h1fff;
    ex(4'h0, 3'h0, 8'h00, 3'h0);
    chk(program_counter_reg, 16'h1fff);
    exec_pc_act = 2'h0;
    exec_pc_len = 2'h1;
    ex(4'h0, 3'h0, 8'h00, 3'h0);
    chk(program_counter_reg, 16'h2000);
    exec_pc_act = 2'h2;
    exec_src_idx = 1'b1;
    ex(4'h1, 3'h1, 8'h01, 3'h0);
    exec_src_idx = 1'b0;
    chk(result_accumulator, 16'h0006);
    ex(4'h3, 3'h1, 8'h07, 3'h0);
    chk({result_accumulator, 6'h00, cpu_flag_state[2:1]}, 16'hff02);
    ex(4'h0, 3'h3, 8'h40, 3'h1);
    chk({stack_top_pointer, stack_push_addr}, 16'h4040);
    exec_flags_restore = 1'b1;
    exec_flags_value = 8'hff;
    ex(4'h0, 3'h0, 8'h00, 3'h0);
    exec_flags_restore = 1'b0;
    chk(cpu_flag_state, 16'h0017);
    rst_n = 1'b0;
    @(negedge clk_sys);
    chk({result_accumulator, cpu_flag_state}, 16'h0002);
    final_report();
  end
endmodule // testbench
